// ==== design/opt_odt_transition.sv ====
// termination mode control around precharge power-down with dll off
// assumes cke and odt arrive from pins, refresh strobe from the command decoder on clk
`timescale 1ns/10ps
module opt_odt_transition
	import opt_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic cke_i,
	input wire logic odt_i,
	input wire logic refresh_cmd_i,
	input wire logic dll_off_in_pd_i,
	input wire logic [LAT_W-1:0] cwl_i,
	input wire logic [LAT_W-1:0] al_i,
	output logic rtt_on_o,
	output logic entry_window_o,
	output logic exit_window_o,
	output logic rtt_uncertain_o,
	output logic [1:0] mode_o,
	output logic [CNT_W-1:0] tanpd_cyc_o,
	output logic [CNT_W-1:0] rtt_chg_min_cyc_o,
	output logic [CNT_W-1:0] rtt_chg_max_cyc_o
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic cke_m_q, cke_s_q, cke_p_q;
	logic odt_m_q, odt_s_q;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cke_m_q <= 1'b1;
			cke_s_q <= 1'b1;
			cke_p_q <= 1'b1;
			odt_m_q <= 1'b0;
			odt_s_q <= 1'b0;
		end else begin
			cke_m_q <= cke_i;
			cke_s_q <= cke_m_q;
			cke_p_q <= cke_s_q;
			odt_m_q <= odt_i;
			odt_s_q <= odt_m_q;
		end
	end
	wire cke_fall = cke_p_q & ~cke_s_q;
	wire cke_rise = ~cke_p_q & cke_s_q;

	// ---------------------------------------------------------------
	// latency arithmetic
	// ---------------------------------------------------------------
	wire [CNT_W-1:0] wl = CNT_W'(cwl_i) + CNT_W'(al_i);
	// additive latency lengthens both odtl and tANPD
	wire [CNT_W-1:0] odtl = (wl > CNT_W'(ODTL_SUB)) ? wl - CNT_W'(ODTL_SUB) : '0;
	wire [CNT_W-1:0] tanpd = odtl + CNT_W'(TANPD_OVER_ODTL);
	wire [CNT_W-1:0] exit_len = tanpd + CNT_W'(XPDLL_CYC);
	wire [CNT_W-1:0] chg_min = (CNT_W'(ASYNC_MIN_CYC) < odtl) ? CNT_W'(ASYNC_MIN_CYC) : odtl;
	// sync max adds one cycle to cover the tAON/tAOF spread
	wire [CNT_W-1:0] sync_max = odtl + 8'h01;
	wire [CNT_W-1:0] chg_max = (CNT_W'(ASYNC_MAX_CYC) > sync_max) ? CNT_W'(ASYNC_MAX_CYC) : sync_max;

	// ---------------------------------------------------------------
	// refresh in progress
	// ---------------------------------------------------------------
	logic [CNT_W-1:0] rfc_left_q;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rfc_left_q <= '0;
		end else if (refresh_cmd_i) begin
			rfc_left_q <= CNT_W'(RFC_CYC);
		end else if (rfc_left_q != '0) begin
			rfc_left_q <= rfc_left_q - 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// window tracking
	// ---------------------------------------------------------------
	// windows are judged on a timeline lagging by tANPD, so the look-back
	// before the cke edge becomes a count after it
	logic [CNT_W-1:0] fall_cnt_q, rise_cnt_q, ext_q;
	logic fall_seen_q, rise_seen_q;
	wire fall_sat = (fall_cnt_q == '1);
	wire rise_sat = (rise_cnt_q == '1);
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fall_cnt_q <= '0;
			rise_cnt_q <= '0;
			ext_q <= '0;
			fall_seen_q <= 1'b0;
			rise_seen_q <= 1'b0;
		end else begin
			if (cke_fall) begin
				fall_cnt_q <= '0;
				fall_seen_q <= 1'b1;
				ext_q <= rfc_left_q;
			end else if (!fall_sat) begin
				fall_cnt_q <= fall_cnt_q + 8'h01;
			end
			if (cke_rise) begin
				rise_cnt_q <= '0;
				rise_seen_q <= 1'b1;
			end else if (!rise_sat) begin
				rise_cnt_q <= rise_cnt_q + 8'h01;
			end
		end
	end
	wire entry_len_gt = (ext_q > tanpd);
	wire [CNT_W-1:0] entry_len = entry_len_gt ? ext_q : tanpd;
	wire entry_act = dll_off_in_pd_i & fall_seen_q & (fall_cnt_q < entry_len);
	wire exit_act = dll_off_in_pd_i & rise_seen_q & (rise_cnt_q < exit_len);
	// overlapping intervals form one span, so short pulses merge on their own
	wire trans_act = entry_act | exit_act;
	wire pd_async = dll_off_in_pd_i & ~cke_s_q;

	// ---------------------------------------------------------------
	// termination path
	// ---------------------------------------------------------------
	logic [ODT_PIPE_DEPTH-1:0] odt_hist;
	opt_odt_delay #(
		.DEPTH(ODT_PIPE_DEPTH)
	) u_delay (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.odt_i(odt_s_q),
		.hist_o(odt_hist)
	);
	// taps beyond the line read the last one; odtl of zero reads the sampled pin
	wire [CNT_W-1:0] tap_idx = (odtl > CNT_W'(ODT_PIPE_DEPTH)) ? CNT_W'(ODT_PIPE_DEPTH) : odtl;
	wire odt_sync_val = (tap_idx == '0) ? odt_s_q : odt_hist[tap_idx[4:0] - 5'h01];
	wire odt_async_val = odt_s_q;
	opt_mode_t mode_d;
	assign mode_d = trans_act ? OPT_TRANS : (pd_async ? OPT_ASYNC : OPT_SYNC);
	// inside a window async wins: termination already follows the pin
	wire rtt_d = (mode_d == OPT_SYNC) ? odt_sync_val : odt_async_val;

	// ---------------------------------------------------------------
	// output registers
	// ---------------------------------------------------------------
	logic rtt_q, entry_q, exit_q, unc_q;
	logic [1:0] mode_q;
	logic [CNT_W-1:0] tanpd_q, min_q, max_q;
	logic odt_prev_q;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rtt_q <= 1'b0;
			entry_q <= 1'b0;
			exit_q <= 1'b0;
			unc_q <= 1'b0;
			mode_q <= OPT_SYNC;
			tanpd_q <= '0;
			min_q <= '0;
			max_q <= '0;
			odt_prev_q <= 1'b0;
		end else begin
			rtt_q <= rtt_d;
			entry_q <= entry_act;
			exit_q <= exit_act;
			unc_q <= trans_act;
			mode_q <= mode_d;
			tanpd_q <= tanpd;
			min_q <= chg_min;
			max_q <= chg_max;
			odt_prev_q <= odt_s_q;
		end
	end
	assign rtt_on_o = rtt_q;
	assign entry_window_o = entry_q;
	assign exit_window_o = exit_q;
	assign rtt_uncertain_o = unc_q;
	assign mode_o = mode_q;
	assign tanpd_cyc_o = tanpd_q;
	assign rtt_chg_min_cyc_o = min_q;
	assign rtt_chg_max_cyc_o = max_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	chk_window_needs_dll: assert property ((entry_q | exit_q) |-> $past(dll_off_in_pd_i))
		else $error("window open with dll kept on");
	chk_entry_starts_fall: assert property (cke_fall & dll_off_in_pd_i ##1 dll_off_in_pd_i |=> entry_q)
		else $error("entry window not open after cke fall");
	chk_tanpd_value: assert property ((wl > 8'h02) |=> tanpd_q == $past(wl) - 8'h01)
		else $error("tanpd not write latency minus one");
	chk_entry_refresh_ext: assert property (fall_seen_q & dll_off_in_pd_i & (fall_cnt_q < ext_q) |=> entry_q)
		else $error("refresh did not stretch entry window");
	chk_entry_end: assert property (fall_seen_q & (fall_cnt_q >= tanpd) & (fall_cnt_q >= ext_q) |=> !entry_q)
		else $error("entry window overran");
	chk_exit_len: assert property (rise_seen_q & dll_off_in_pd_i & (rise_cnt_q < exit_len) |=> exit_q)
		else $error("exit window short");
	chk_exit_end: assert property (rise_seen_q & (rise_cnt_q >= exit_len) |=> !exit_q)
		else $error("exit window overran");
	chk_span_order: assert property (min_q <= max_q)
		else $error("earliest change later than latest");
	chk_async_direct: assert property ((mode_d != OPT_SYNC) |=> rtt_q == $past(odt_s_q))
		else $error("async termination delayed");
	chk_sync_latency: assert property ((mode_d == OPT_SYNC) & (tap_idx == 8'h03) |=> rtt_q == $past(odt_s_q, 4))
		else $error("sync termination latency wrong");
	chk_merge_span: assert property (trans_act |=> unc_q)
		else $error("overlapping windows left a gap");
	cov_entry: cover property (cke_fall & dll_off_in_pd_i ##1 entry_act);
	cov_refresh_ext: cover property (entry_act & entry_len_gt);
	cov_overlap: cover property (entry_act & exit_act);
	cov_odt_in_window: cover property (trans_act & (odt_s_q != odt_prev_q));
endmodule : opt_odt_transition

// ==== inc/opt_pkg.sv ====
// constants for the termination mode transition block
// assumes one clock that stands for the device clock CK
package opt_pkg;
	// ---------------------------------------------------------------
	// clock and analog delay figures
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 20000;
	localparam int unsigned T_ASYNC_MIN_PS = 2000;
	localparam int unsigned T_ASYNC_MAX_PS = 8500;
	localparam int unsigned T_RFC_PS = 260000;
	localparam int unsigned T_XPDLL_PS = 24000;
	// least times round up, longest round down, never below one cycle
	localparam int unsigned ASYNC_MIN_CYC = (T_ASYNC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned ASYNC_MAX_RAW = T_ASYNC_MAX_PS / CLK_PERIOD_PS;
	localparam int unsigned ASYNC_MAX_CYC = (ASYNC_MAX_RAW < 1) ? 1 : ASYNC_MAX_RAW;
	localparam int unsigned RFC_CYC = (T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned XPDLL_CYC = (T_XPDLL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// ---------------------------------------------------------------
	// latency arithmetic
	// ---------------------------------------------------------------
	localparam int unsigned ODTL_SUB = 2;
	localparam int unsigned TANPD_OVER_ODTL = 1;
	localparam int unsigned LAT_W = 4;
	localparam int unsigned CNT_W = 8;
	localparam int unsigned ODT_PIPE_DEPTH = 32;
	// termination path mode
	typedef enum logic [1:0] {
		OPT_SYNC = 2'b00,
		OPT_ASYNC = 2'b01,
		OPT_TRANS = 2'b10
	} opt_mode_t;
endpackage : opt_pkg

// ==== design/opt_odt_delay.sv ====
// sampled odt history line, one tap per clock of latency
// assumes its input is already in the clock domain
`timescale 1ns/10ps
module opt_odt_delay
	import opt_pkg::*;
#(
	parameter int unsigned DEPTH = ODT_PIPE_DEPTH
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic odt_i,
	output logic [DEPTH-1:0] hist_o
);
	logic [DEPTH-1:0] hist_q;
	assign hist_o = hist_q;
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hist_q[0] <= 1'b0;
		end else begin
			hist_q[0] <= odt_i;
		end
	end
	genvar gi;
	generate
		for (gi = 1; gi < DEPTH; gi++) begin : g_tap
			always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					hist_q[gi] <= 1'b0;
				end else begin
					hist_q[gi] <= hist_q[gi-1];
				end
			end
		end
	endgenerate
endmodule : opt_odt_delay

// ==== testbench/opt_ctrl_model.sv ====
// controller side model: drives cke, odt and refresh strobe
// assumes bench requests change just after a rising edge
`timescale 1ns/10ps
module opt_ctrl_model (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic cke_req_i,
	input wire logic odt_req_i,
	input wire logic ref_req_i,
	input wire logic rtt_uncertain_i,
	output logic cke_o,
	output logic odt_o,
	output logic refresh_cmd_o,
	output logic traffic_ok_o
);
	// ---------------------------------------------------------------
	// pin drive
	// ---------------------------------------------------------------
	assign cke_o = cke_req_i;
	assign odt_o = odt_req_i;
	assign refresh_cmd_o = ref_req_i & rst_b_i;
	// no bus traffic while termination state is unknown
	assign traffic_ok_o = ~rtt_uncertain_i;
endmodule : opt_ctrl_model

// ==== testbench/opt_odt_transition_tb.sv ====
// bench for the termination mode transition block
// assumes package constants RFC_CYC 13 and XPDLL_CYC 2
`timescale 1ns/10ps
module opt_odt_transition_tb
	import opt_pkg::*;
;
	typedef struct {logic [3:0] cwl; logic [3:0] al; logic [7:0] tanpd; logic [7:0] mn; logic [7:0] mx;} opt_row_t;
	logic clk_sys_i = 0, rst_b_i = 0, cke_req = 1, odt_req = 0, ref_req = 0, dll_off = 1;
	logic cke, odt, refresh, rtt_on, ent, ext, unc, ok;
	logic [3:0] cwl = 4'h5, al = 4'h0;
	logic [1:0] mode;
	logic [7:0] tanpd, mn, mx;
	int err_total = 0, checked = 0, cyc = 0, n;
	opt_row_t rows[5] = '{'{4'h5, 4'h0, 8'h04, 8'h01, 8'h04}, '{4'h5, 4'h5, 8'h09, 8'h01, 8'h09},
		'{4'h6, 4'h0, 8'h05, 8'h01, 8'h05}, '{4'h2, 4'h0, 8'h01, 8'h00, 8'h01}, '{4'h8, 4'h7, 8'h0E, 8'h01, 8'h0E}};
	always #10 clk_sys_i = ~clk_sys_i;
	opt_ctrl_model model (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cke_req_i(cke_req), .odt_req_i(odt_req),
		.ref_req_i(ref_req), .rtt_uncertain_i(unc), .cke_o(cke), .odt_o(odt), .refresh_cmd_o(refresh),
		.traffic_ok_o(ok));
	opt_odt_transition uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cke_i(cke), .odt_i(odt),
		.refresh_cmd_i(refresh), .dll_off_in_pd_i(dll_off), .cwl_i(cwl), .al_i(al), .rtt_on_o(rtt_on),
		.entry_window_o(ent), .exit_window_o(ext), .rtt_uncertain_o(unc), .mode_o(mode), .tanpd_cyc_o(tanpd),
		.rtt_chg_min_cyc_o(mn), .rtt_chg_max_cyc_o(mx));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task stop_test;
		if (err_total == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic sel(input int k);
		return (k == 0) ? rtt_on : (k == 1) ? ent : (k == 2) ? ext : unc;
	endfunction : sel
	task step(input int c);
		repeat (c) @(posedge clk_sys_i);
		#1;
	endtask : step
	// edges until the chosen output is first seen high
	task lat(input int k, output int c);
		c = 0;
		while (sel(k) !== 1'b1 && c < 40) begin
			step(1);
			c++;
		end
	endtask : lat
	// edges for which the chosen output stays high
	task len(input int k, output int c);
		c = 1;
		step(1);
		while (sel(k) === 1'b1 && c < 300) begin
			c++;
			step(1);
		end
	endtask : len
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			stop_test;
		end
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		step(5);
		rst_b_i = 1;
		step(1);
		check(mode, OPT_SYNC);
		check(unc, 0);
		foreach (rows[i]) begin
			cwl = rows[i].cwl;
			al = rows[i].al;
			step(3);
			check(tanpd, rows[i].tanpd);
			check(mn, rows[i].mn);
			check(mx, rows[i].mx);
		end
		cwl = 4'h5;
		al = 4'h0;
		step(3);
		odt_req = 1;
		lat(0, n);
		check(n, 6);
		odt_req = 0;
		step(8);
		cke_req = 0;
		lat(1, n);
		check(n, 4);
		check(mode, OPT_TRANS);
		len(1, n);
		check(n, 4);
		check(mode, OPT_ASYNC);
		odt_req = 1;
		lat(0, n);
		check(n, 3);
		odt_req = 0;
		step(4);
		check(rtt_on, 0);
		cke_req = 1;
		lat(2, n);
		check(n, 4);
		len(2, n);
		check(n, 6);
		check(mode, OPT_SYNC);
		ref_req = 1;
		step(1);
		ref_req = 0;
		cke_req = 0;
		lat(1, n);
		check(ok, 0);
		len(1, n);
		check(n > 4 && n < 13, 1);
		cke_req = 1;
		step(12);
		cke_req = 0;
		step(2);
		cke_req = 1;
		lat(3, n);
		len(3, n);
		check(n, 8);
		step(4);
		cke_req = 0;
		step(12);
		cke_req = 1;
		step(2);
		cke_req = 0;
		lat(3, n);
		len(3, n);
		check(n, 6);
		step(12);
		dll_off = 0;
		step(2);
		cke_req = 1;
		n = 0;
		repeat (12) begin
			step(1);
			n += (ent | ext | unc) ? 1 : 0;
		end
		check(n, 0);
		stop_test;
	end
endmodule : opt_odt_transition_tb
